// ---- rtu_consts.svh ----
// register map, field positions, reset values and timing of the timer unit
`ifndef RTU_CONSTS_SVH
`define RTU_CONSTS_SVH

// ------------------------------------------------------------
// register indices; the byte address is four times the index
// ------------------------------------------------------------
`define IDX_MODE 6'h2A
`define IDX_PRESCALE 6'h2B
`define IDX_RELOAD_HI 6'h2C
`define IDX_RELOAD_LO 6'h2D
`define IDX_COUNT_HI 6'h2E
`define IDX_COUNT_LO 6'h2F
`define IDX_CTRL 6'h38
`define IDX_STATUS 6'h39
`define IDX_IRQ_STAT 6'h3A
`define IDX_IRQ_MASK 6'h3B

// ------------------------------------------------------------
// reset values and field positions
// ------------------------------------------------------------
`define MODE_RST 8'h00
`define PRESCALE_RST 8'h00
`define RELOAD_RST 16'h0000
`define IRQ_MASK_RST 2'h0
`define CTRL_EVEN_BIT 0
`define CTRL_MULTI_BIT 1
`define CTRL_START_BIT 2
`define CTRL_STOP_BIT 3
`define IRQ_EXPIRY_BIT 0
`define IRQ_WRAP_BIT 1
`define FIFTH_RX_BIT 3'h4

// ------------------------------------------------------------
// timing: reference and system clock in kHz
// ------------------------------------------------------------
`define REF_FREQ_KHZ 18'h034F8
`define CLK_FREQ_KHZ 18'h186A0

`endif

// ---- rtu_pkg.sv ----
// types shared by the timer unit modules
package rtu_pkg;

	typedef enum logic [1:0] {
		GATE_FREE = 2'b00,
		GATE_SECURE = 2'b01,
		GATE_AUX = 2'b10,
		GATE_UNDEF = 2'b11
	} gate_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} tstate_type;

	typedef struct packed {
		logic auto_start_on_tx;
		gate_type gate_select;
		logic auto_reload_enable;
		logic [3:0] prescale_upper;
	} mode_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		mode_type mode;
		logic [7:0] prescale_lower;
		logic [15:0] reload;
		logic [15:0] count;
		logic even_divide_select;
		logic multi_frame_receive;
		tstate_type st;
		logic [2:0] rx_cnt;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic counting;
		logic [7:0] rdata;
		logic pready;
		logic pslverr;
		logic irq;
	} unit_state_type;

	typedef struct packed {
		logic [16:0] acc;
		logic [13:0] pcnt;
		logic tick;
	} div_state_type;

endpackage : rtu_pkg

// ---- pin_sync.sv ----
// two-flop synchroniser for the gate pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sync_state_type;

	sync_state_type state_r;
	sync_state_type state_nxt;

	always_comb begin
		state_nxt.meta = async_i;
		state_nxt.stable = state_r.meta;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign sync_o = state_r.stable;
endmodule : pin_sync

`default_nettype wire

// ---- prescale_divider.sv ----
// fractional reference generator and timer prescaler
`timescale 1ns/1ps
`default_nettype none
`include "rtu_consts.svh"

module prescale_divider (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic restart_i,
	input wire logic [11:0] prescale_i,
	input wire logic even_divide_i,
	output logic tick_o
);
	rtu_pkg::div_state_type state_r;
	rtu_pkg::div_state_type state_nxt;
	logic [17:0] acc_sum;
	logic ref_hit;
	logic [13:0] div_last;
	logic tick_cause;

	// reference edges jitter by one system cycle; the mean rate is exact
	assign acc_sum = {1'b0, state_r.acc} + `REF_FREQ_KHZ;
	assign ref_hit = acc_sum >= `CLK_FREQ_KHZ;
	// divisor is 2p+1, or 2p+2 with even rule; this is divisor minus one
	assign div_last = {1'b0, prescale_i, even_divide_i};
	// at or past the end, so a prescaler lowered mid-period cannot overrun
	assign tick_cause = ref_hit && !restart_i && state_r.pcnt >= div_last;

	always_comb begin
		state_nxt = state_r;
		state_nxt.tick = 1'b0;
		if (ref_hit) begin
			state_nxt.acc = 17'(acc_sum - `CLK_FREQ_KHZ);
		end else begin
			state_nxt.acc = acc_sum[16:0];
		end
		if (restart_i) begin
			state_nxt.pcnt = 14'h0000;
		end else if (tick_cause) begin
			state_nxt.pcnt = 14'h0000;
			state_nxt.tick = 1'b1;
		end else if (ref_hit) begin
			state_nxt.pcnt = state_r.pcnt + 14'h0001;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign tick_o = state_r.tick;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_tick_gap;
		tick_o |=> !tick_o [*6];
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("timer ticks closer than one reference period");

	property p_tick_cause;
		tick_o |-> $past(tick_cause);
	endproperty
	a_tick_cause: assert property (p_tick_cause)
		else $error("timer tick without a full prescaler count");

	property p_restart;
		restart_i |=> (state_r.pcnt == 14'h0000 && !tick_o);
	endproperty
	a_restart: assert property (p_restart)
		else $error("prescaler not restarted on start");
endmodule : prescale_divider

`default_nettype wire

// ---- reader_timer_unit.sv ----
// timer unit top: apb registers, start and stop control, countdown
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtu_consts.svh"

// Behaviour
// - with auto start set, every transmission end starts the timer unless stop-immediately is written in the same cycle
// - auto start, no multi-frame: stop on the fifth received bit
// - auto start with multi-frame: only stop-immediately or expiry stops the timer
// - auto start clear: transmit and receive events are ignored
// - gate select: 00 free, 01 secure-link pin, 10 auxiliary pin one
// - counting flag is one while the gate lets the timer count
// - auto reload restarts the countdown from the reload value
// - without auto reload, count to zero and set the expiry flag
// - prescaler is 12 bits, upper four from mode register bits 3..0
// - even rule clear: tick is reference over 2p+1
// - even rule set: tick is reference over 2p+2
// - reload value is two writable bytes, high then low address
// - counter copies reload only on start and on an auto reload wrap; reload writes wait
// - upper counter byte readable, read only
// - lower counter byte readable at the following address
module reader_timer_unit (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic tx_end_i,
	input wire logic rx_bit_i,
	input wire logic secure_link_input_pin_i,
	input wire logic auxiliary_pin_one_i,
	output logic counting_flag_o,
	output logic running_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// state and local signals
	// ------------------------------------------------------------
	localparam rtu_pkg::unit_state_type RST_STATE = '{
		mode: `MODE_RST,
		prescale_lower: `PRESCALE_RST,
		reload: `RELOAD_RST,
		st: rtu_pkg::ST_IDLE,
		irq_mask: `IRQ_MASK_RST,
		default: '0
	};

	rtu_pkg::unit_state_type state_r;
	rtu_pkg::unit_state_type state_nxt;
	rtu_pkg::apb_req_type req;
	logic [1:0] pins_sync;
	logic timer_tick;
	logic [5:0] idx;
	logic aligned;
	logic setup;
	logic access;
	logic wr_ok;
	logic rd_ok;
	logic [7:0] rd_byte;
	logic rd_err;
	logic running;
	logic gate_ok;
	logic start_wr;
	logic stop_wr;
	logic start_evt;
	logic stop_rx;
	logic tick_run;
	logic at_end;
	logic expire_evt;
	logic wrap_evt;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;

	// ------------------------------------------------------------
	// bus request decode
	// ------------------------------------------------------------
	assign req = '{
		psel: psel_i,
		penable: penable_i,
		pwrite: pwrite_i,
		paddr: paddr_i,
		pwdata: pwdata_i
	};
	assign idx = req.paddr[7:2];
	assign aligned = req.paddr[1:0] == 2'h0;
	assign setup = req.psel && !req.penable;
	// answer is prepared in setup, so every access ends in its first cycle
	assign access = req.psel && req.penable && state_r.pready;
	assign wr_ok = access && req.pwrite && !state_r.pslverr;
	assign rd_ok = access && !req.pwrite && !state_r.pslverr;

	// ------------------------------------------------------------
	// submodules
	// ------------------------------------------------------------
	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.async_i({auxiliary_pin_one_i, secure_link_input_pin_i}),
		.sync_o(pins_sync)
	);

	prescale_divider u_prescale_divider (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.restart_i(start_evt),
		.prescale_i({state_r.mode.prescale_upper, state_r.prescale_lower}),
		.even_divide_i(state_r.even_divide_select),
		.tick_o(timer_tick)
	);

	// ------------------------------------------------------------
	// gating and timer events
	// ------------------------------------------------------------
	always_comb begin
		case (state_r.mode.gate_select)
			rtu_pkg::GATE_SECURE: begin
				gate_ok = pins_sync[0];
			end
			rtu_pkg::GATE_AUX: begin
				gate_ok = pins_sync[1];
			end
			default: begin
				gate_ok = 1'b1;
			end
		endcase
	end

	assign running = state_r.st == rtu_pkg::ST_RUN;
	assign start_wr = wr_ok && idx == `IDX_CTRL &&
		req.pwdata[`CTRL_START_BIT];
	assign stop_wr = wr_ok && idx == `IDX_CTRL &&
		req.pwdata[`CTRL_STOP_BIT];
	// protocol events act only with auto start set
	assign start_evt = start_wr ||
		(state_r.mode.auto_start_on_tx && tx_end_i);
	assign stop_rx = state_r.mode.auto_start_on_tx &&
		!state_r.multi_frame_receive && running && rx_bit_i &&
		state_r.rx_cnt == `FIFTH_RX_BIT;
	assign tick_run = running && gate_ok && timer_tick;
	assign at_end = state_r.count <= 16'h0001;
	assign expire_evt = tick_run && at_end &&
		!state_r.mode.auto_reload_enable;
	assign wrap_evt = tick_run && at_end &&
		state_r.mode.auto_reload_enable;

	assign irq_set = {wrap_evt, expire_evt};
	// only bits that the read returned are cleared; later sets survive
	assign irq_clr = (rd_ok && idx == `IDX_IRQ_STAT) ?
		state_r.rdata[1:0] : 2'h0;

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	always_comb begin
		rd_byte = 8'h00;
		rd_err = 1'b0;
		if (!aligned) begin
			rd_err = 1'b1;
		end else if (idx == `IDX_MODE) begin
			rd_byte = state_r.mode;
		end else if (idx == `IDX_PRESCALE) begin
			rd_byte = state_r.prescale_lower;
		end else if (idx == `IDX_RELOAD_HI) begin
			rd_byte = state_r.reload[15:8];
		end else if (idx == `IDX_RELOAD_LO) begin
			rd_byte = state_r.reload[7:0];
		end else if (idx == `IDX_COUNT_HI) begin
			rd_byte = state_r.count[15:8];
		end else if (idx == `IDX_COUNT_LO) begin
			rd_byte = state_r.count[7:0];
		end else if (idx == `IDX_CTRL) begin
			rd_byte = {6'h00, state_r.multi_frame_receive,
				state_r.even_divide_select};
		end else if (idx == `IDX_STATUS) begin
			rd_byte = {6'h00, state_r.counting, running};
		end else if (idx == `IDX_IRQ_STAT) begin
			rd_byte = {6'h00, state_r.irq_stat};
		end else if (idx == `IDX_IRQ_MASK) begin
			rd_byte = {6'h00, state_r.irq_mask};
		end else begin
			rd_err = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.pready = setup;
		state_nxt.pslverr = setup && rd_err;
		if (setup) begin
			state_nxt.rdata = rd_byte;
		end

		// count registers are read only; writes to them are dropped
		if (wr_ok) begin
			if (idx == `IDX_MODE) begin
				state_nxt.mode = req.pwdata[7:0];
			end else if (idx == `IDX_PRESCALE) begin
				state_nxt.prescale_lower = req.pwdata[7:0];
			end else if (idx == `IDX_RELOAD_HI) begin
				state_nxt.reload[15:8] = req.pwdata[7:0];
			end else if (idx == `IDX_RELOAD_LO) begin
				state_nxt.reload[7:0] = req.pwdata[7:0];
			end else if (idx == `IDX_CTRL) begin
				state_nxt.even_divide_select =
					req.pwdata[`CTRL_EVEN_BIT];
				state_nxt.multi_frame_receive =
					req.pwdata[`CTRL_MULTI_BIT];
			end else if (idx == `IDX_IRQ_MASK) begin
				state_nxt.irq_mask = req.pwdata[1:0];
			end
		end

		// received bits since the last start, held at four
		if (start_evt) begin
			state_nxt.rx_cnt = 3'h0;
		end else if (running && rx_bit_i &&
			state_r.rx_cnt < `FIFTH_RX_BIT) begin
			state_nxt.rx_cnt = state_r.rx_cnt + 3'h1;
		end

		case (state_r.st)
			rtu_pkg::ST_IDLE: begin
				if (start_evt && !stop_wr) begin
					state_nxt.st = rtu_pkg::ST_RUN;
					state_nxt.count = state_r.reload;
				end
			end
			rtu_pkg::ST_RUN: begin
				if (stop_wr) begin
					state_nxt.st = rtu_pkg::ST_IDLE;
				end else if (start_evt) begin
					state_nxt.count = state_r.reload;
				end else if (stop_rx) begin
					state_nxt.st = rtu_pkg::ST_IDLE;
				end else if (wrap_evt) begin
					state_nxt.count = state_r.reload;
				end else if (expire_evt) begin
					state_nxt.count = 16'h0000;
					state_nxt.st = rtu_pkg::ST_IDLE;
				end else if (tick_run) begin
					state_nxt.count = state_r.count - 16'h0001;
				end
			end
			default: begin
				state_nxt.st = rtu_pkg::ST_IDLE;
			end
		endcase

		// a set in the same cycle as a read clear is kept
		state_nxt.irq_stat = (state_r.irq_stat & ~irq_clr) | irq_set;
		state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask);
		state_nxt.counting = running && gate_ok;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= RST_STATE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata_o = {24'h000000, state_r.rdata};
	assign pready_o = state_r.pready;
	assign pslverr_o = state_r.pslverr;
	assign counting_flag_o = state_r.counting;
	assign running_o = running;
	assign irq_o = state_r.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_loaded;
		##1 (running && state_r.count == $past(state_r.reload));
	endsequence

	property p_auto_start;
		(state_r.mode.auto_start_on_tx && tx_end_i && !stop_wr)
			|-> s_loaded;
	endproperty
	a_auto_start: assert property (p_auto_start)
		else $error("transmission end did not start the timer");

	property p_fifth_stop;
		(running && state_r.mode.auto_start_on_tx &&
			!state_r.multi_frame_receive && rx_bit_i &&
			state_r.rx_cnt == 3'h4 && !start_evt && !stop_wr)
			|=> !running;
	endproperty
	a_fifth_stop: assert property (p_fifth_stop)
		else $error("timer still running after fifth received bit");

	property p_multi_hold;
		(running && state_r.multi_frame_receive && !stop_wr &&
			!expire_evt) |=> running;
	endproperty
	a_multi_hold: assert property (p_multi_hold)
		else $error("reception stopped timer in multi-frame mode");

	property p_stop_now;
		(running && stop_wr) |=> (!running ##1 !running);
	endproperty
	a_stop_now: assert property (p_stop_now)
		else $error("stop-immediately did not stop the timer");

	property p_no_auto;
		(!state_r.mode.auto_start_on_tx && !running && !start_wr)
			|=> !running;
	endproperty
	a_no_auto: assert property (p_no_auto)
		else $error("timer started by protocol with auto start clear");

	property p_gate_hold;
		(running && !gate_ok && !start_evt && !stop_wr)
			|=> $stable(state_r.count);
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("counter moved while gated off");

	property p_counting;
		(running && gate_ok) |=> counting_flag_o;
	endproperty
	a_counting: assert property (p_counting)
		else $error("counting flag low while the timer counts");

	property p_wrap;
		(wrap_evt && !start_evt && !stop_wr && !stop_rx) |-> s_loaded;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("auto reload did not restart from reload value");

	property p_expire;
		(expire_evt && !start_evt && !stop_wr && !stop_rx) |=>
			(!running && state_r.count == 16'h0000 &&
			state_r.irq_stat[`IRQ_EXPIRY_BIT]);
	endproperty
	a_expire: assert property (p_expire)
		else $error("expiry did not stop at zero and flag");

	property p_reload_write;
		(wr_ok && running && !start_evt && !tick_run &&
			(idx == `IDX_RELOAD_HI || idx == `IDX_RELOAD_LO))
			|=> $stable(state_r.count);
	endproperty
	a_reload_write: assert property (p_reload_write)
		else $error("reload write disturbed a running count");

	property p_decrement;
		(tick_run && !at_end && !start_evt && !stop_wr && !stop_rx)
			|=> (state_r.count == $past(state_r.count) - 16'h0001);
	endproperty
	a_decrement: assert property (p_decrement)
		else $error("counter did not decrement on tick");
endmodule : reader_timer_unit

`default_nettype wire

// ---- reader_timer_unit_test.sv ----
// self-checking testbench of the reader timer unit
`timescale 1ns/1ps
`default_nettype none
`include "rtu_consts.svh"

module reader_timer_unit_test;
	typedef struct {
		string what;
		logic [32:0] value;
	} note_type;

	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h00000000;
	logic tx_end_i = 1'b0;
	logic rx_bit_i = 1'b0;
	logic secure_link_input_pin_i = 1'b0;
	logic auxiliary_pin_one_i = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic counting_flag_o;
	logic running_o;
	logic irq_o;
	note_type notes[$];
	int failures = 0;
	int samples_checked = 0;
	int seed_value;
	int n;
	int e;
	logic [1:0] g;
	logic gf;
	logic [7:0] r_hi;
	logic [7:0] r_lo;

	reader_timer_unit u_reader_timer_unit (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.psel_i(psel_i),
		.penable_i(penable_i),
		.pwrite_i(pwrite_i),
		.paddr_i(paddr_i),
		.pwdata_i(pwdata_i),
		.prdata_o(prdata_o),
		.pready_o(pready_o),
		.pslverr_o(pslverr_o),
		.tx_end_i(tx_end_i),
		.rx_bit_i(rx_bit_i),
		.secure_link_input_pin_i(secure_link_input_pin_i),
		.auxiliary_pin_one_i(auxiliary_pin_one_i),
		.counting_flag_o(counting_flag_o),
		.running_o(running_o),
		.irq_o(irq_o)
	);

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// comparison and closing
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [32:0] seen,
			input logic [32:0] expected);
		samples_checked++;
		if (seen !== expected) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, expected, seen);
		end
	endtask : check

	task automatic conclude();
		if (failures == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	// ------------------------------------------------------------
	// apb master; expectations are queued at setup
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [5:0] idx,
			input logic [7:0] wd, input logic [32:0] expected, input string what);
		int k;
		k = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {24'($urandom()), wd};
		notes.push_back('{what, expected});
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 50);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (k >= 50) begin
			failures++;
			conclude();
		end
	endtask : apb

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h000000000, "write response");
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [7:0] v,
			input string what);
		apb(1'b0, idx, 8'h00, {9'h000, 16'h0000, v}, what);
	endtask : rd

	// writes drop read data, so only the error bit is judged for them
	always @(posedge clk_i) begin : watch
		note_type nt;
		if (psel_i && penable_i && pready_o === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			check(nt.what, {pslverr_o, pwrite_i ? 32'h00000000 : prdata_o},
				nt.value);
		end
	end

	task automatic wait_run(input logic lvl, input int bound, output int cnt);
		cnt = 0;
		while (running_o !== lvl && cnt < bound) begin
			@(posedge clk_i);
			cnt++;
		end
		if (cnt >= bound) begin
			failures++;
			conclude();
		end
	endtask : wait_run

	task automatic pulse(input logic rx, input int times);
		repeat (times) begin
			@(posedge clk_i);
			tx_end_i <= !rx;
			rx_bit_i <= rx;
			@(posedge clk_i);
			tx_end_i <= 1'b0;
			rx_bit_i <= 1'b0;
		end
	endtask : pulse

	// reference runs at 13.56 MHz against a 100 MHz clock; jitter allowed
	task automatic timed(input logic even, input logic [11:0] p,
			input logic [15:0] rl, input int div, input logic mask);
		wr(`IDX_MODE, {4'h0, p[11:8]});
		wr(`IDX_PRESCALE, p[7:0]);
		wr(`IDX_RELOAD_HI, rl[15:8]);
		wr(`IDX_RELOAD_LO, rl[7:0]);
		wr(`IDX_IRQ_MASK, {7'h00, mask});
		wr(`IDX_CTRL, {5'h00, 1'b1, 1'b0, even});
		e = int'(rl) * div * 100000 / 13560;
		wait_run(1'b1, 5, n);
		wait_run(1'b0, e + 100, n);
		check("expiry cycles", (n > e - 12) && (n < e + 12), 1'b1);
		repeat (2) @(posedge clk_i);
		check("irq line", irq_o, mask);
		rd(`IDX_IRQ_STAT, 8'h01, "expiry flag");
		rd(`IDX_IRQ_STAT, 8'h00, "expiry flag cleared");
		rd(`IDX_COUNT_LO, 8'h00, "count at expiry");
	endtask : timed

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		seed_value = $urandom(14);
		repeat (4) @(posedge clk_i);
		reset_n_i <= 1'b1;
		rd(`IDX_MODE, 8'h00, "mode reset");
		rd(`IDX_PRESCALE, 8'h00, "prescale reset");
		rd(`IDX_RELOAD_HI, 8'h00, "reload high reset");
		rd(`IDX_RELOAD_LO, 8'h00, "reload low reset");
		rd(`IDX_IRQ_MASK, 8'h00, "mask reset");
		wr(`IDX_COUNT_HI, 8'h5A);
		rd(`IDX_COUNT_HI, 8'h00, "count high read only");
		apb(1'b1, 6'h30, 8'h11, {1'b1, 32'h00000000}, "unmapped error");
		timed(1'b0, 12'h100, 16'h0002, 513, 1'b1);
		timed(1'b1, 12'h003, 16'h0014, 8, 1'b0);
		// auto reload keeps the timer running and flags each wrap
		wr(`IDX_MODE, 8'h10);
		wr(`IDX_RELOAD_LO, 8'h03);
		wr(`IDX_CTRL, 8'h04);
		// first wrap lands about 155 cycles after the start
		repeat (200) @(posedge clk_i);
		rd(`IDX_STATUS, 8'h03, "running after wraps");
		rd(`IDX_IRQ_STAT, 8'h02, "wrap flag only");
		wr(`IDX_CTRL, 8'h08);
		rd(`IDX_STATUS, 8'h00, "stopped by software");
		// slowest prescaler: no tick lands while the counter is read
		wr(`IDX_MODE, 8'h0F);
		wr(`IDX_PRESCALE, 8'hFF);
		r_hi = 8'($urandom_range(1, 255));
		r_lo = 8'($urandom());
		wr(`IDX_RELOAD_HI, r_hi);
		wr(`IDX_RELOAD_LO, r_lo);
		wr(`IDX_CTRL, 8'h04);
		rd(`IDX_COUNT_HI, r_hi, "count high after start");
		rd(`IDX_COUNT_LO, r_lo, "count low after start");
		wr(`IDX_RELOAD_HI, ~r_hi);
		wr(`IDX_RELOAD_LO, ~r_lo);
		rd(`IDX_COUNT_HI, r_hi, "count kept on reload write");
		rd(`IDX_RELOAD_LO, ~r_lo, "reload low readback");
		wr(`IDX_CTRL, 8'h04);
		rd(`IDX_COUNT_HI, ~r_hi, "count high after restart");
		rd(`IDX_COUNT_LO, ~r_lo, "count low after restart");
		// protocol events with auto start clear and set
		wr(`IDX_CTRL, 8'h08);
		pulse(1'b0, 1);
		rd(`IDX_STATUS, 8'h00, "tx ignored");
		wr(`IDX_CTRL, 8'h04);
		pulse(1'b1, 5);
		rd(`IDX_STATUS, 8'h03, "rx ignored");
		wr(`IDX_MODE, 8'h8F);
		wr(`IDX_CTRL, 8'h08);
		pulse(1'b0, 1);
		rd(`IDX_STATUS, 8'h03, "started by tx");
		pulse(1'b1, 4);
		rd(`IDX_STATUS, 8'h03, "four rx bits");
		pulse(1'b1, 1);
		rd(`IDX_STATUS, 8'h00, "fifth rx bit");
		wr(`IDX_CTRL, 8'h0A);
		pulse(1'b0, 1);
		pulse(1'b1, 6);
		rd(`IDX_STATUS, 8'h03, "multi frame keeps running");
		wr(`IDX_CTRL, 8'h0A);
		rd(`IDX_STATUS, 8'h00, "stop immediately");
		wr(`IDX_CTRL, 8'h00);
		// every gate code with each pin open in turn
		for (int c = 0; c < 4; c++) begin
			g = c[1:0];
			wr(`IDX_MODE, {1'b0, g, 1'b0, 4'hF});
			wr(`IDX_CTRL, 8'h04);
			for (int s = 0; s < 2; s++) begin
				secure_link_input_pin_i <= s[0];
				auxiliary_pin_one_i <= !s[0];
				repeat (4) @(posedge clk_i);
				gf = (g == 2'b01) ? s[0] : (g == 2'b10) ? !s[0] : 1'b1;
				check("counting flag pin", counting_flag_o, gf);
				rd(`IDX_STATUS, {6'h00, gf, 1'b1}, "gate flag");
			end
		end
		conclude();
	end
endmodule : reader_timer_unit_test

`default_nettype wire
